// *** logic/alm_pkg.sv ***
// Constants shared by the local sample memory subsystem and its bank.
// Assumes a single clock domain and a synchronous active-low reset.
// Function
// - Four separate 16KB local sample banks carry engine input and output data.
// - Each bank is 1024 words of 128 bits.
// - Banks take DMA transfers at up to 128 bits per cycle.
// - Banks are reachable over a 128-bit system bus.
// - DMA must avoid engine banks; a same-bank clash is reported as an error.
// - The four banks form one contiguous address range crossing bank limits.
// - Banks zero and one double as ADC ping and pong capture buffers.
// - A 512-byte parameter-set memory is loaded one set at a time.
// - Engine, banks and processor share one clock domain, nominally 200 MHz.
// - The parameter-set memory holds sixteen sets of eight 32-bit words.
package alm_pkg;
  localparam int BANK_NUM   = 4;
  localparam int BANK_WORDS = 1024;
  localparam int WORD_W     = 128;
  localparam int BANK_BYTES = 16384;
  localparam int BE_W       = WORD_W / 8;
  localparam int IDX_W      = 10;
  localparam int BSEL_W     = 2;
  localparam int ADDR_W     = IDX_W + BSEL_W;
  localparam int ADC_BANKS  = 2;

  localparam int PS_SETS    = 16;
  localparam int PS_REGS    = 8;
  localparam int PS_REG_W   = 32;
  localparam int PS_BYTES   = 512;
  localparam int PS_SET_W   = 4;
  localparam int PS_REG_IW  = 3;
  localparam int PS_ADDR_W  = PS_SET_W + PS_REG_IW;
  localparam int PS_DEPTH   = PS_SETS * PS_REGS;
  localparam int PS_LINE_W  = PS_REGS * PS_REG_W;

  localparam int ERR_W        = 2;
  localparam int ERR_DMA_CLASH = 0;
  localparam int ERR_SAME_BANK = 1;

  localparam int NOM_CLK_MHZ = 200;
  localparam int SYS_CLK_MHZ = 25;

  typedef logic [ADDR_W-1:0]   alm_addr_t;
  typedef logic [IDX_W-1:0]    alm_idx_t;
  typedef logic [WORD_W-1:0]   alm_word_t;
  typedef logic [BE_W-1:0]     alm_be_t;
  typedef logic [BSEL_W-1:0]   alm_bsel_t;
  typedef logic [ERR_W-1:0]    alm_err_t;
  typedef logic [PS_ADDR_W-1:0] alm_ps_addr_t;
  typedef logic [PS_SET_W-1:0]  alm_ps_set_t;
  typedef logic [PS_REG_W-1:0]  alm_ps_reg_t;
  typedef logic [PS_LINE_W-1:0] alm_ps_line_t;
endpackage

// *** logic/alm_bank.sv ***
// One local sample bank: single port, byte-enabled writes, registered read.
// Assumes the caller grants at most one access per cycle.
`timescale 1ns/1ps
module alm_bank (
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  input  wire logic             en_i,
  input  wire logic             we_i,
  input  wire alm_pkg::alm_idx_t  idx_i,
  input  wire alm_pkg::alm_word_t wdata_i,
  input  wire alm_pkg::alm_be_t   be_i,
  output alm_pkg::alm_word_t      rdata_o
);
  import alm_pkg::*;

  alm_word_t rdata_q;

  // Each byte lane keeps its own storage and read flop, so a full line
  // moves per cycle and a partial write leaves the other lanes alone.
  for (genvar l = 0; l < BE_W; l++) begin : g_lane
    logic [7:0] lane_q [0:BANK_WORDS-1];

    always_ff @(posedge clk_sys_i) begin
      if (en_i && we_i && be_i[l]) begin
        lane_q[idx_i] <= wdata_i[l*8 +: 8];
      end
    end

    always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
        rdata_q[l*8 +: 8] <= '0;
      end else if (en_i && !we_i) begin
        rdata_q[l*8 +: 8] <= lane_q[idx_i];
      end
    end
  end

  assign rdata_o = rdata_q;
endmodule

// *** logic/alm_mem_top.sv ***
// Local sample memory subsystem: four banks, access arbitration, clash
// reporting and the parameter-set memory.
// Assumes engine, ADC capture and DMA all run on clk_sys_i.
`timescale 1ns/1ps
module alm_mem_top (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rstn_i,
  // System DMA side, word addressed over the contiguous range.
  input  wire logic                 dma_req_i,
  input  wire logic                 dma_we_i,
  input  wire alm_pkg::alm_addr_t   dma_addr_i,
  input  wire alm_pkg::alm_word_t   dma_wdata_i,
  input  wire alm_pkg::alm_be_t     dma_be_i,
  output logic                      dma_gnt_o,
  output logic                      dma_rvalid_o,
  output alm_pkg::alm_word_t        dma_rdata_o,
  // Engine source read port.
  input  wire logic                 src_rd_i,
  input  wire alm_pkg::alm_addr_t   src_addr_i,
  output logic                      src_rvalid_o,
  output alm_pkg::alm_word_t        src_rdata_o,
  // Engine destination write port.
  input  wire logic                 dst_wr_i,
  input  wire alm_pkg::alm_addr_t   dst_addr_i,
  input  wire alm_pkg::alm_word_t   dst_wdata_i,
  input  wire alm_pkg::alm_be_t     dst_be_i,
  // Banks the engine currently owns for a running operation.
  input  wire logic [3:0]           eng_bank_busy_i,
  // ADC capture into ping (bank 0) or pong (bank 1).
  input  wire logic                 adc_wr_i,
  input  wire logic                 adc_pong_i,
  input  wire alm_pkg::alm_idx_t    adc_idx_i,
  input  wire alm_pkg::alm_word_t   adc_wdata_i,
  input  wire alm_pkg::alm_be_t     adc_be_i,
  // Error status and its clear, one bit per cause.
  input  wire alm_pkg::alm_err_t    err_clr_i,
  output alm_pkg::alm_err_t         engine_error_code_o,
  // Parameter-set memory: processor write port and state machine load.
  input  wire logic                 ps_wr_i,
  input  wire alm_pkg::alm_ps_addr_t ps_waddr_i,
  input  wire alm_pkg::alm_ps_reg_t ps_wdata_i,
  input  wire logic                 ps_load_i,
  input  wire alm_pkg::alm_ps_set_t ps_set_i,
  output logic                      ps_valid_o,
  output alm_pkg::alm_ps_line_t     ps_line_o
);
  import alm_pkg::*;

  alm_bsel_t dma_bank;
  alm_bsel_t src_bank;
  alm_bsel_t dst_bank;
  logic [BANK_NUM-1:0] bank_busy;
  alm_word_t bank_rdata [BANK_NUM];
  logic      dma_clash;
  logic      same_bank;
  logic      dma_rd_go;

  // Upper address bits pick the bank, so regions run across bank edges.
  assign dma_bank = dma_addr_i[ADDR_W-1:IDX_W];
  assign src_bank = src_addr_i[ADDR_W-1:IDX_W];
  assign dst_bank = dst_addr_i[ADDR_W-1:IDX_W];

  // Each bank port is steered to capture, then engine, then DMA. The DMA
  // is never granted a bank that someone else holds, so engine data is safe.
  for (genvar b = 0; b < BANK_NUM; b++) begin : g_bank
    localparam alm_bsel_t BID = alm_bsel_t'(b);
    logic      adc_hit;
    logic      dst_hit;
    logic      src_hit;
    logic      dma_hit;
    logic      en;
    logic      we;
    alm_idx_t  idx;
    alm_word_t wdata;
    alm_be_t   be;

    assign adc_hit = (b < ADC_BANKS) && adc_wr_i
                     && (adc_pong_i == BID[0]);
    assign dst_hit = dst_wr_i && (dst_bank == BID);
    assign src_hit = src_rd_i && (src_bank == BID);
    assign dma_hit = dma_req_i && (dma_bank == BID);
    assign bank_busy[b] = adc_hit || dst_hit || src_hit
                          || eng_bank_busy_i[b];

    always_comb begin
      en    = 1'b1;
      we    = 1'b1;
      idx   = dst_addr_i[IDX_W-1:0];
      wdata = dst_wdata_i;
      be    = dst_be_i;
      if (adc_hit) begin
        idx   = adc_idx_i;
        wdata = adc_wdata_i;
        be    = adc_be_i;
      end else if (dst_hit) begin
        we = 1'b1;
      end else if (src_hit) begin
        we  = 1'b0;
        idx = src_addr_i[IDX_W-1:0];
      end else if (dma_hit && !bank_busy[b]) begin
        we    = dma_we_i;
        idx   = dma_addr_i[IDX_W-1:0];
        wdata = dma_wdata_i;
        be    = dma_be_i;
      end else begin
        en = 1'b0;
        we = 1'b0;
      end
    end

    alm_bank u_bank (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .en_i      (en),
      .we_i      (we),
      .idx_i     (idx),
      .wdata_i   (wdata),
      .be_i      (be),
      .rdata_o   (bank_rdata[b])
    );
  end

  assign dma_clash = dma_req_i && bank_busy[dma_bank];
  assign dma_gnt_o = dma_req_i && !bank_busy[dma_bank];
  assign dma_rd_go = dma_gnt_o && !dma_we_i;
  // A source read colliding with a destination write loses to the write.
  assign same_bank = src_rd_i && dst_wr_i && (src_bank == dst_bank);

  // Read returns pass a second register so every data output is a flop.
  logic      src_p1_q;
  logic      dma_p1_q;
  alm_bsel_t src_b1_q;
  alm_bsel_t dma_b1_q;
  logic      src_rvalid_q;
  logic      dma_rvalid_q;
  alm_word_t src_rdata_q;
  alm_word_t dma_rdata_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      src_p1_q <= 1'b0;
      src_b1_q <= '0;
      dma_p1_q <= 1'b0;
      dma_b1_q <= '0;
    end else begin
      src_p1_q <= src_rd_i && !same_bank;
      src_b1_q <= src_bank;
      dma_p1_q <= dma_rd_go;
      dma_b1_q <= dma_bank;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      src_rvalid_q <= 1'b0;
      src_rdata_q  <= '0;
      dma_rvalid_q <= 1'b0;
      dma_rdata_q  <= '0;
    end else begin
      src_rvalid_q <= src_p1_q;
      dma_rvalid_q <= dma_p1_q;
      if (src_p1_q) begin
        src_rdata_q <= bank_rdata[src_b1_q];
      end
      if (dma_p1_q) begin
        dma_rdata_q <= bank_rdata[dma_b1_q];
      end
    end
  end

  assign src_rvalid_o = src_rvalid_q;
  assign src_rdata_o  = src_rdata_q;
  assign dma_rvalid_o = dma_rvalid_q;
  assign dma_rdata_o  = dma_rdata_q;

  // Sticky error bits; a new event in the clearing cycle keeps its bit set.
  alm_err_t err_q;
  alm_err_t err_set;

  always_comb begin
    err_set                = '0;
    err_set[ERR_DMA_CLASH] = dma_clash;
    err_set[ERR_SAME_BANK] = same_bank;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~err_clr_i) | err_set;
    end
  end

  assign engine_error_code_o = err_q;

  // Parameter-set memory, sixteen lines of eight words each.
  alm_ps_reg_t  ps_mem_q [0:PS_DEPTH-1];
  alm_ps_line_t ps_line_q;
  logic         ps_valid_q;

  always_ff @(posedge clk_sys_i) begin
    if (ps_wr_i) begin
      ps_mem_q[ps_waddr_i] <= ps_wdata_i;
    end
  end

  // A whole set moves in one cycle; a write to the same set in that cycle
  // is seen by the next load, not this one.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ps_line_q  <= '0;
      ps_valid_q <= 1'b0;
    end else begin
      ps_valid_q <= ps_load_i;
      if (ps_load_i) begin
        for (int r = 0; r < PS_REGS; r++) begin
          ps_line_q[r*PS_REG_W +: PS_REG_W] <=
            ps_mem_q[{ps_set_i, r[PS_REG_IW-1:0]}];
        end
      end
    end
  end

  assign ps_valid_o = ps_valid_q;
  assign ps_line_o  = ps_line_q;
endmodule

// *** verification/alm_mem_top_asserts.sv ***
// Port-level checks for the local sample memory subsystem.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module alm_mem_top_asserts
  import alm_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic       dma_req_i,
  input wire logic       dma_we_i,
  input wire alm_addr_t  dma_addr_i,
  input wire logic       dma_gnt_o,
  input wire logic       dma_rvalid_o,
  input wire logic       src_rd_i,
  input wire alm_addr_t  src_addr_i,
  input wire logic       src_rvalid_o,
  input wire logic       dst_wr_i,
  input wire alm_addr_t  dst_addr_i,
  input wire logic [3:0] eng_bank_busy_i,
  input wire logic       adc_wr_i,
  input wire logic       adc_pong_i,
  input wire alm_err_t   err_clr_i,
  input wire alm_err_t   engine_error_code_o,
  input wire logic       ps_load_i,
  input wire logic       ps_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_rd;
    dma_req_i && !dma_we_i && dma_gnt_o |-> ##2 dma_rvalid_o;
  endproperty
  a_rd: assert property (p_rd) else $error("dma read lost");
  property p_busy;
    dma_req_i && eng_bank_busy_i[dma_addr_i[11:10]] |-> !dma_gnt_o;
  endproperty
  a_busy: assert property (p_busy) else $error("busy granted");
  property p_clash;
    dma_req_i && !dma_gnt_o |=> engine_error_code_o[0];
  endproperty
  a_clash: assert property (p_clash) else $error("clash missed");
  property p_adc;
    adc_wr_i && dma_req_i && dma_addr_i[11:10] == {1'b0, adc_pong_i}
      |-> !dma_gnt_o;
  endproperty
  a_adc: assert property (p_adc) else $error("capture granted");
  property p_hold;
    engine_error_code_o[0] && !err_clr_i[0] |=> engine_error_code_o[0];
  endproperty
  a_hold: assert property (p_hold) else $error("error lost");
  property p_same;
    src_rd_i && dst_wr_i && src_addr_i[11:10] == dst_addr_i[11:10]
      |=> engine_error_code_o[1] ##1 !src_rvalid_o;
  endproperty
  a_same: assert property (p_same) else $error("same bank missed");
  property p_load;
    ps_load_i |=> ps_valid_o;
  endproperty
  a_load: assert property (p_load) else $error("set not loaded");
  property p_one;
    ps_valid_o |-> $past(ps_load_i);
  endproperty
  a_one: assert property (p_one) else $error("stray set valid");
endmodule
bind alm_mem_top alm_mem_top_asserts alm_mem_top_asserts_i (.clk_sys_i,
  .rstn_i, .dma_req_i, .dma_we_i, .dma_addr_i, .dma_gnt_o, .dma_rvalid_o,
  .src_rd_i, .src_addr_i, .src_rvalid_o, .dst_wr_i, .dst_addr_i,
  .eng_bank_busy_i, .adc_wr_i, .adc_pong_i, .err_clr_i,
  .engine_error_code_o, .ps_load_i, .ps_valid_o);

// *** verification/alm_dma_model.sv ***
// Partner model of the system DMA engine on the wide system bus.
// Assumes the bench pulses go_i once per transfer while idle.
`timescale 1ns/1ps
module alm_dma_model
  import alm_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      rstn_i,
  input  wire logic      go_i,
  input  wire logic      we_i,
  input  wire alm_addr_t addr_i,
  input  wire alm_word_t wdata_i,
  input  wire logic      dma_gnt_i,
  output logic           dma_req_o = 1'b0,
  output logic           dma_we_o = 1'b0,
  output alm_addr_t      dma_addr_o = '0,
  output alm_word_t      dma_wdata_o = '0,
  output alm_be_t        dma_be_o,
  output logic           done_o = 1'b0
);
  assign dma_be_o = '1;
  // A refused request is held unchanged until granted, never dropped.
  always @(posedge clk_sys_i) begin
    done_o <= dma_req_o && dma_gnt_i;
    if (!rstn_i) begin
      dma_req_o <= 1'b0;
    end else if (go_i) begin
      {dma_req_o, dma_we_o} <= {1'b1, we_i};
      {dma_addr_o, dma_wdata_o} <= {addr_i, wdata_i};
    end else if (dma_req_o && dma_gnt_i) begin
      // Released address and data lines flip so a stale value cannot pass for a held one.
      {dma_req_o, dma_addr_o} <= {1'b0, ~dma_addr_o};
      dma_wdata_o <= ~dma_wdata_o;
    end
  end
endmodule

// *** verification/tb_alm_mem_top.sv ***
// Self-checking bench for the local sample memory subsystem.
// Assumes the DMA model and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb_alm_mem_top;
  import alm_pkg::*;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
  localparam alm_word_t D1 = {4{32'h1a2b3c4d}};
  localparam alm_word_t D2 = {4{32'h55aa0ff0}};
  int           err_total = 0, total_checks = 0, cyc = 0;
  logic         clk_sys_i = 1'b0, rstn_i = 1'b0, go = 1'b0, mwe = 1'b0;
  logic         src_rd_i = 1'b0, dst_wr_i = 1'b0, adc_wr_i = 1'b0;
  logic         adc_pong_i = 1'b0, ps_wr_i = 1'b0, ps_load_i = 1'b0;
  logic         done, dma_req_i, dma_we_i, dma_gnt_o, dma_rvalid_o;
  logic         src_rvalid_o, ps_valid_o;
  logic [3:0]   eng_bank_busy_i = 4'h0;
  alm_addr_t    maddr = '0, src_addr_i = '0, dst_addr_i = '0, dma_addr_i;
  alm_word_t    mwd = '0, dst_wdata_i = '0, adc_wdata_i = '0;
  alm_word_t    dma_wdata_i, dma_rdata_o, src_rdata_o;
  alm_be_t      dma_be_i, dst_be_i = '1, adc_be_i = '1;
  alm_idx_t     adc_idx_i = '0;
  alm_err_t     err_clr_i = '0, engine_error_code_o;
  alm_ps_addr_t ps_waddr_i = '0;
  alm_ps_reg_t  ps_wdata_i = '0;
  alm_ps_set_t  ps_set_i = '0;
  alm_ps_line_t ps_line_o, exp_line;
  alm_mem_top alm_mem_top_i (.clk_sys_i, .rstn_i, .dma_req_i, .dma_we_i,
    .dma_addr_i, .dma_wdata_i, .dma_be_i, .dma_gnt_o, .dma_rvalid_o,
    .dma_rdata_o, .src_rd_i, .src_addr_i, .src_rvalid_o, .src_rdata_o,
    .dst_wr_i, .dst_addr_i, .dst_wdata_i, .dst_be_i, .eng_bank_busy_i,
    .adc_wr_i, .adc_pong_i, .adc_idx_i, .adc_wdata_i, .adc_be_i, .err_clr_i,
    .engine_error_code_o, .ps_wr_i, .ps_waddr_i, .ps_wdata_i, .ps_load_i,
    .ps_set_i, .ps_valid_o, .ps_line_o);
  alm_dma_model alm_dma_model_i (.clk_sys_i, .rstn_i, .go_i(go), .we_i(mwe),
    .addr_i(maddr), .wdata_i(mwd), .dma_gnt_i(dma_gnt_o),
    .dma_req_o(dma_req_i), .dma_we_o(dma_we_i), .dma_addr_o(dma_addr_i),
    .dma_wdata_o(dma_wdata_i), .dma_be_o(dma_be_i), .done_o(done));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The whole run needs under a hundred cycles; this ceiling cuts a hang.
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic dma(input logic w, input alm_addr_t a, input alm_word_t d);
    @(posedge clk_sys_i);
    {go, mwe, maddr, mwd} <= {1'b1, w, a, d};
    @(posedge clk_sys_i);
    go <= 1'b0;
    for (int k = 0; k < 30 && !done; k++) @(negedge clk_sys_i);
    if (w) `CHK("dma done", 1'b1, done)
    for (int k = 0; k < 4 && !w && !dma_rvalid_o; k++) @(negedge clk_sys_i);
    if (!w) `CHK("dma read", {1'b1, d}, {dma_rvalid_o, dma_rdata_o})
  endtask
  task automatic src(input alm_addr_t a, input alm_word_t e);
    @(posedge clk_sys_i);
    {src_rd_i, src_addr_i} <= {1'b1, a};
    @(posedge clk_sys_i);
    src_rd_i <= 1'b0;
    for (int k = 0; k < 4 && !src_rvalid_o; k++) @(negedge clk_sys_i);
    `CHK("src read", {1'b1, e}, {src_rvalid_o, src_rdata_o})
  endtask
  task automatic clr(input alm_err_t e);
    `CHK("error held", e, engine_error_code_o)
    @(posedge clk_sys_i);
    err_clr_i <= 2'b11;
    @(posedge clk_sys_i);
    err_clr_i <= 2'b00;
    @(negedge clk_sys_i);
    `CHK("error clear", 2'b00, engine_error_code_o)
  endtask
  task automatic t_clash;
    @(posedge clk_sys_i);
    eng_bank_busy_i <= 4'h4;
    fork
      dma(1'b0, 12'hbff, D1);
      begin
        tick(4);
        @(negedge clk_sys_i);
        `CHK("clash flag", 3'b001, {dma_gnt_o, engine_error_code_o})
        @(posedge clk_sys_i);
        eng_bank_busy_i <= 4'h0;
      end
    join
    clr(2'b01);
  endtask
  task automatic t_same;
    @(posedge clk_sys_i);
    {src_rd_i, src_addr_i} <= {1'b1, 12'h804};
    {dst_wr_i, dst_addr_i, dst_wdata_i} <= {1'b1, 12'h804, D2};
    @(posedge clk_sys_i);
    {src_rd_i, dst_wr_i} <= 2'b00;
    tick(1);
    @(negedge clk_sys_i);
    `CHK("dropped read", 1'b0, src_rvalid_o)
    src(12'h804, D2);
    clr(2'b10);
  endtask
  task automatic t_adc;
    @(posedge clk_sys_i);
    {adc_wr_i, adc_pong_i, adc_idx_i, adc_wdata_i} <= {2'b11, 10'h005, D1};
    fork
      dma(1'b1, 12'h406, D2);
      begin
        tick(3);
        adc_wr_i <= 1'b0;
      end
    join
    src(12'h405, D1);
    dma(1'b0, 12'h406, D2);
    clr(2'b01);
  endtask
  task automatic t_lane;
    @(posedge clk_sys_i);
    {dst_wr_i, dst_addr_i, dst_wdata_i} <= {1'b1, 12'hbff, D2};
    dst_be_i <= 16'h00ff;
    @(posedge clk_sys_i);
    dst_wr_i <= 1'b0;
    dst_be_i <= '1;
    src(12'hbff, {D1[127:64], D2[63:0]});
  endtask
  task automatic t_ps;
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_sys_i);
      {ps_wr_i, ps_waddr_i} <= {1'b1, 4'hf, r[2:0]};
      ps_wdata_i <= 32'hc0de0000 | r;
      exp_line[32*r +: 32] = 32'hc0de0000 | r;
    end
    @(posedge clk_sys_i);
    {ps_wr_i, ps_load_i, ps_set_i} <= {2'b01, 4'hf};
    @(posedge clk_sys_i);
    ps_load_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("param set", {1'b1, exp_line}, {ps_valid_o, ps_line_o})
  endtask
  initial begin
    tick(6);
    rstn_i <= 1'b1;
    dma(1'b1, 12'hbff, D1);
    dma(1'b1, 12'hc00, D2);
    dma(1'b0, 12'hbff, D1);
    dma(1'b0, 12'hc00, D2);
    src(12'hc00, D2);
    t_clash();
    t_same();
    t_adc();
    t_lane();
    t_ps();
    tick(4);
    final_report();
  end
endmodule
